// File: rtl/sci_rx_pkg.sv
// Constants, register map and types for the serial receive/baud block
// What this block does
// - Overrun sets its flag, keeps the holding register, shift register overwritten.
// - Overrun raises receive interrupt when enabled and global mask clear.
// - Error flags clear only by status read then data read.
// - Sixteen samples per bit; majority of 8,9,10 is value; disagreement flags noise.
// - Noisy frame still transfers data; noise flag rises with full flag, no interrupt.
// - Start needs valid falling edge and agreeing samples 8,9,10, else noise.
// - False start discards frame; hidden noise shown with next valid frame.
// - Missing stop bit or break sets framing flag; data still transferred.
// - Tx and rx rates: clock over 16, one shared coarse factor, own power of two each.
// - Non-zero fine prescale divides the power-of-two output again, ahead of the by-16; zero bypasses.
// - While muted no receive flag sets and receive interrupts are suppressed.
// - Idle-wake mode: idle frame clears mute, idle flag not set.
// - Address-wake mode: word with MSB one clears mute and is received normally.
// - Frame is start, 8 or 9 data bits (parity included), stop.
// - Address wake looks at the data MSB, never the parity bit.
// - Parity makes ones over 7 or 8 low bits plus parity even or odd.
// - Transmit with parity replaces data MSB by computed parity.
// - Receive parity failure sets its flag; interrupt when parity interrupt enabled.
// - Sample counter resynchronised on every start bit.
// - Nine-bit words put the MSB in the ninth-bit field, not data register.
// - Valid start: three ones before edge, samples 3,5,7 and 8,9,10 zero.
package sci_rx_pkg;
    localparam logic [2:0] ADDR_STATUS   = 3'h0;
    localparam logic [2:0] ADDR_DATA     = 3'h1;
    localparam logic [2:0] ADDR_CTRL1    = 3'h2;
    localparam logic [2:0] ADDR_CTRL2    = 3'h3;
    localparam logic [2:0] ADDR_BAUD     = 3'h4;
    localparam logic [2:0] ADDR_TX_FINE  = 3'h5;
    localparam logic [2:0] ADDR_RX_FINE  = 3'h6;
    localparam logic [7:0] STATUS_RESET  = 8'hc0;
    localparam logic [3:0] SAMPLE_LAST   = 4'hf;
    localparam int         CLK_HZ        = 25000000;

    // Control one: ninth bit rx(7), ninth tx(6), unused, word_length_nine(4),
    // rouse_by_address(3), parity_enable(2), parity_odd_sel(1), parity_irq_en(0)
    typedef struct packed {
        logic rx_ninth_bit;
        logic tx_ninth_bit;
        logic spare;
        logic word_length_nine;
        logic rouse_by_address;
        logic parity_enable;
        logic parity_odd_sel;
        logic parity_irq_en;
    } ctrl_one_t;

    // Control two: tx_irq_en(7) tc_irq_en(6) rx_irq_en(5) idle_irq_en(4)
    // tx_enable(3) rx_enable(2) mute_request(1) send_break(0)
    typedef struct packed {
        logic tx_irq_en;
        logic tc_irq_en;
        logic rx_irq_en;
        logic idle_irq_en;
        logic tx_enable;
        logic rx_enable;
        logic mute_request;
        logic send_break;
    } ctrl_two_t;

    typedef struct packed {
        logic [1:0] coarse_div_sel;
        logic [2:0] tx_divider_sel;
        logic [2:0] rx_divider_sel;
    } baud_sel_t;

    typedef enum logic [1:0] { RX_IDLE, RX_START, RX_DATA, RX_STOP } rx_state_t;
    typedef enum logic [1:0] { TX_IDLE, TX_START, TX_DATA, TX_STOP } tx_state_t;
endpackage

// File: rtl/sci_rx_core.sv
// Serial receiver errors, baud generation, mute wake-up and parity
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module sci_rx_core
    import sci_rx_pkg::*;
(
    input  wire logic       CLOCK_I,
    input  wire logic       RST_I,
    input  wire logic [2:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    input  wire logic       GLOB_MASK_I,
    input  wire logic       RX_LINE_I,
    output logic            TX_LINE_O,
    output logic            IRQ_O
);
    // Coarse factor minus one per select code
    function automatic logic [3:0] coarse_top(input logic [1:0] sel);
        case (sel)
            2'h0:    coarse_top = 4'h0;
            2'h1:    coarse_top = 4'h2;
            2'h2:    coarse_top = 4'h3;
            default: coarse_top = 4'hc;
        endcase
    endfunction

    // Parity bit over the low data bits
    function automatic logic parity_of(input logic [7:0] d, input logic nine, input logic odd);
        parity_of = (nine ? ^d : ^d[6:0]) ^ odd;
    endfunction

    ctrl_one_t  ctrl1;
    ctrl_two_t  ctrl2;
    baud_sel_t  baud;
    logic [7:0] tx_fine, rx_fine;
    logic       rx_full, tx_empty, tx_done, idle_flag, overrun, noise, framing, parity_err;
    logic       status_seen, hidden_noise;
    logic [7:0] rx_holding;

    // Baud chain: coarse, then power of two, then fine; the divide by 16 is the
    // sixteen samples per bit, so one tick here is one sample time
    logic [3:0] coarse_cnt;
    logic [6:0] pow_cnt_tx, pow_cnt_rx;
    logic [7:0] fine_cnt_tx, fine_cnt_rx;
    logic [3:0] tx_sub;
    // Coarse stage counts on every clock edge
    wire        coarse_tick = (coarse_cnt == coarse_top(baud.coarse_div_sel));
    wire [6:0]  pow_top_tx  = 7'((8'h1 << baud.tx_divider_sel) - 8'h1);
    wire [6:0]  pow_top_rx  = 7'((8'h1 << baud.rx_divider_sel) - 8'h1);
    wire        pow_tick_tx = coarse_tick && (pow_cnt_tx == pow_top_tx);
    wire        pow_tick_rx = coarse_tick && (pow_cnt_rx == pow_top_rx);
    // Fine prescaler bypassed when zero
    wire        tx_tick = pow_tick_tx && ((tx_fine == 8'h0) || (fine_cnt_tx == tx_fine - 8'h1));
    wire        rx_tick = pow_tick_rx && ((rx_fine == 8'h0) || (fine_cnt_rx == rx_fine - 8'h1));
    // Receiver takes one sample per rx tick and sixteen per bit; the transmitter
    // counts sixteen tx ticks per bit, so both share the same divide by 16
    wire        rx_sample = rx_tick;
    wire        tx_bit    = tx_tick && (tx_sub == 4'hf);

    // Counters are not restarted by a baud write: software keeps the dividers
    // still while either direction is enabled, so a part-counted tick never hits a frame
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            coarse_cnt  <= 4'h0;
            pow_cnt_tx  <= 7'h0;
            pow_cnt_rx  <= 7'h0;
            fine_cnt_tx <= 8'h0;
            fine_cnt_rx <= 8'h0;
            tx_sub      <= 4'h0;
        end else begin
            coarse_cnt <= coarse_tick ? 4'h0 : coarse_cnt + 4'h1;
            if (coarse_tick) begin
                pow_cnt_tx <= pow_tick_tx ? 7'h0 : pow_cnt_tx + 7'h1;
                pow_cnt_rx <= pow_tick_rx ? 7'h0 : pow_cnt_rx + 7'h1;
            end
            if (pow_tick_tx) begin
                fine_cnt_tx <= tx_tick ? 8'h0 : fine_cnt_tx + 8'h1;
            end
            if (pow_tick_rx) begin
                fine_cnt_rx <= rx_tick ? 8'h0 : fine_cnt_rx + 8'h1;
            end
            if (tx_tick) begin
                tx_sub <= tx_sub + 4'h1;
            end
        end
    end

    // Receiver: 16 samples per bit from the rx tick
    rx_state_t  rx_state;
    logic [3:0] samp_cnt;
    logic [3:0] bit_cnt;
    logic [2:0] pre_hist;
    logic [2:0] mid;
    logic       edge_bad, bit_noise;
    logic [8:0] shift;
    logic [3:0] ones_run;
    wire        rx_on      = ctrl2.rx_enable;
    wire  [3:0] data_bits  = ctrl1.word_length_nine ? 4'h9 : 4'h8;
    wire        maj        = (mid[2] & mid[1]) | (mid[2] & mid[0]) | (mid[1] & mid[0]);
    wire        mid_split  = (mid != 3'h0) && (mid != 3'h7);
    wire        bit_end    = rx_sample && (samp_cnt == SAMPLE_LAST);
    wire        frame_done = (rx_state == RX_STOP) && bit_end;
    // Newest sample shifts in at the bottom, so after sample 10 the window
    // holds samples 8, 9 and 10 in that order
    wire [2:0]  mid_now    = {mid[1:0], RX_LINE_I};
    wire        stop_maj   = (mid[2] & mid[1]) | (mid[2] & mid[0]) | (mid[1] & mid[0]);
    wire        f_nine     = ctrl1.word_length_nine;
    wire        f_msb      = f_nine ? shift[8] : shift[7];
    // Address wake reads data MSB; with parity that position is below the parity bit
    wire        addr_bit   = ctrl1.parity_enable ? (f_nine ? shift[7] : shift[6]) : f_msb;
    wire        par_fail   = ctrl1.parity_enable &&
                             ((f_nine ? ^shift[8:0] : ^shift[7:0]) != ctrl1.parity_odd_sel);
    wire        muted      = ctrl2.mute_request;
    wire        addr_wake  = frame_done && muted && ctrl1.rouse_by_address && addr_bit;
    wire        idle_seen  = frame_done && (shift == (f_nine ? 9'h1ff : 9'h0ff)) && stop_maj;
    wire        idle_wake  = idle_seen && muted && !ctrl1.rouse_by_address;
    wire        deliver    = frame_done && (!muted || addr_wake);
    wire        do_overrun = deliver && rx_full;
    wire        clear_seq  = RD_I && (ADDR_I == ADDR_DATA) && status_seen;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            rx_state <= RX_IDLE;
            samp_cnt <= 4'h0;
            bit_cnt  <= 4'h0;
            pre_hist <= 3'h0;
            mid      <= 3'h0;
            edge_bad <= 1'b0;
            bit_noise<= 1'b0;
            shift    <= 9'h0;
        end else if (!rx_on) begin
            rx_state <= RX_IDLE;
            pre_hist <= 3'h0;
        end else if (rx_sample) begin
            samp_cnt <= samp_cnt + 4'h1;
            if (samp_cnt == 4'h7 || samp_cnt == 4'h8 || samp_cnt == 4'h9) begin
                mid <= mid_now;
            end
            case (rx_state)
                RX_IDLE: begin
                    pre_hist <= {pre_hist[1:0], RX_LINE_I};
                    if (!RX_LINE_I) begin
                        // Sample counter restarts on each start edge
                        rx_state  <= RX_START;
                        samp_cnt  <= 4'h1;
                        edge_bad  <= (pre_hist != 3'h7);
                        bit_noise <= 1'b0;
                        bit_cnt   <= 4'h0;
                    end
                end
                RX_START: begin
                    if ((samp_cnt == 4'h2 || samp_cnt == 4'h4 || samp_cnt == 4'h6) && RX_LINE_I) begin
                        edge_bad <= 1'b1;
                    end
                    if (samp_cnt == 4'h9) begin
                        if (mid_now == 3'h0) begin
                            bit_noise <= edge_bad;
                        end else begin
                            rx_state <= RX_IDLE;
                            pre_hist <= 3'h0;
                        end
                    end
                    if (samp_cnt == SAMPLE_LAST) begin
                        rx_state <= RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (samp_cnt == SAMPLE_LAST) begin
                        shift     <= f_nine ? {maj, shift[8:1]} : {1'b0, maj, shift[7:1]};
                        bit_noise <= bit_noise | mid_split;
                        bit_cnt   <= bit_cnt + 4'h1;
                        if (bit_cnt == data_bits - 4'h1) begin
                            rx_state <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (samp_cnt == SAMPLE_LAST) begin
                        rx_state <= RX_IDLE;
                        pre_hist <= {3{stop_maj}};
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // Hidden noise from a discarded false start, shown on the next delivered frame
    wire false_start = rx_sample && rx_on && (rx_state == RX_START) && (samp_cnt == 4'h9) && (mid_now != 3'h0);
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            hidden_noise <= 1'b0;
        end else if (false_start && !muted) begin
            hidden_noise <= 1'b1;
        end else if (deliver) begin
            hidden_noise <= 1'b0;
        end
    end

    // Flags: hardware set wins over the software clear sequence
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            rx_full    <= 1'b0;
            overrun    <= 1'b0;
            noise      <= 1'b0;
            framing    <= 1'b0;
            parity_err <= 1'b0;
            idle_flag  <= 1'b0;
            rx_holding <= 8'h0;
            status_seen<= 1'b0;
        end else begin
            if (RD_I && ADDR_I == ADDR_STATUS) begin
                status_seen <= 1'b1;
            end else if (clear_seq) begin
                status_seen <= 1'b0;
            end
            if (clear_seq) begin
                rx_full    <= 1'b0;
                overrun    <= 1'b0;
                noise      <= 1'b0;
                framing    <= 1'b0;
                parity_err <= 1'b0;
                idle_flag  <= 1'b0;
            end
            if (do_overrun) begin
                overrun <= 1'b1;
            end else if (deliver) begin
                rx_full    <= 1'b1;
                rx_holding <= f_nine ? shift[7:0] : shift[7:0];
                noise      <= bit_noise | mid_split | hidden_noise;
                framing    <= !stop_maj;
                parity_err <= par_fail;
                if (idle_seen && !muted) begin
                    idle_flag <= 1'b1;
                end
            end
        end
    end

    // Registers
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl1   <= '0;
            ctrl2   <= '0;
            baud    <= '0;
            tx_fine <= 8'h0;
            rx_fine <= 8'h0;
        end else begin
            if (deliver && !do_overrun && f_nine) begin
                ctrl1.rx_ninth_bit <= shift[8];
            end
            if (WR_I) begin
                case (ADDR_I)
                    ADDR_CTRL1:   ctrl1[6:0] <= WDATA_I[6:0];
                    ADDR_CTRL2:   ctrl2      <= WDATA_I;
                    ADDR_BAUD:    baud       <= WDATA_I;
                    ADDR_TX_FINE: tx_fine    <= WDATA_I;
                    ADDR_RX_FINE: rx_fine    <= WDATA_I;
                    default: ;
                endcase
            end
            if (addr_wake || idle_wake) begin
                ctrl2.mute_request <= 1'b0;
            end
        end
    end

    // Transmitter with parity substitution
    tx_state_t  tx_state;
    logic [8:0] tx_shift;
    logic [3:0] tx_cnt;
    logic [8:0] tx_buf;
    wire        data_wr = WR_I && (ADDR_I == ADDR_DATA);
    wire [7:0]  tx_low  = WDATA_I;
    wire        tx_par  = parity_of(tx_low, f_nine, ctrl1.parity_odd_sel);
    wire [8:0]  tx_word = !ctrl1.parity_enable ? {ctrl1.tx_ninth_bit, tx_low} :
                          f_nine ? {tx_par, tx_low} : {1'b0, tx_par, tx_low[6:0]};
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            tx_state  <= TX_IDLE;
            tx_shift  <= 9'h0;
            tx_cnt    <= 4'h0;
            tx_buf    <= 9'h0;
            tx_empty  <= 1'b1;
            tx_done   <= 1'b1;
            TX_LINE_O <= 1'b1;
        end else begin
            if (data_wr) begin
                tx_buf   <= tx_word;
                tx_empty <= 1'b0;
                tx_done  <= 1'b0;
            end
            if (tx_bit && ctrl2.tx_enable) begin
                case (tx_state)
                    TX_IDLE: if (!tx_empty) begin
                        tx_state  <= TX_START;
                        tx_shift  <= tx_buf;
                        tx_empty  <= 1'b1;
                        TX_LINE_O <= 1'b0;
                    end
                    TX_START: begin
                        tx_state  <= TX_DATA;
                        tx_cnt    <= 4'h0;
                        TX_LINE_O <= tx_shift[0];
                        tx_shift  <= {1'b0, tx_shift[8:1]};
                    end
                    TX_DATA: begin
                        tx_cnt <= tx_cnt + 4'h1;
                        if (tx_cnt == data_bits - 4'h1) begin
                            tx_state  <= TX_STOP;
                            TX_LINE_O <= 1'b1;
                        end else begin
                            TX_LINE_O <= tx_shift[0];
                            tx_shift  <= {1'b0, tx_shift[8:1]};
                        end
                    end
                    TX_STOP: begin
                        tx_state <= TX_IDLE;
                        tx_done  <= 1'b1;
                    end
                    default: tx_state <= TX_IDLE;
                endcase
            end
        end
    end

    // Read port, data one cycle after the strobe
    wire [7:0] status_word = {tx_empty, tx_done, rx_full, idle_flag, overrun, noise, framing, parity_err};
    wire [7:0] read_mux    = (ADDR_I == ADDR_STATUS)  ? status_word :
                             (ADDR_I == ADDR_DATA)    ? rx_holding :
                             (ADDR_I == ADDR_CTRL1)   ? ctrl1 :
                             (ADDR_I == ADDR_CTRL2)   ? ctrl2 :
                             (ADDR_I == ADDR_BAUD)    ? baud :
                             (ADDR_I == ADDR_TX_FINE) ? tx_fine :
                             (ADDR_I == ADDR_RX_FINE) ? rx_fine : 8'h0;
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            RDATA_O <= 8'h0;
        end else begin
            RDATA_O <= RD_I ? read_mux : 8'h0;
        end
    end

    // Interrupt: muted receiver suppresses receive sources
    wire rx_src = (ctrl2.rx_irq_en && (rx_full || overrun)) ||
                  (ctrl1.parity_irq_en && parity_err) ||
                  (ctrl2.idle_irq_en && idle_flag);
    wire tx_src = (ctrl2.tx_irq_en && tx_empty) || (ctrl2.tc_irq_en && tx_done);
    assign IRQ_O = !GLOB_MASK_I && ((rx_src && !muted) || tx_src);

    chk_overrun_keeps: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        do_overrun |=> overrun && rx_holding == $past(rx_holding)) else $error("overrun lost data");
    chk_clear_needs_seq: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        $fell(overrun) |-> $past(clear_seq)) else $error("overrun cleared without sequence");
    chk_noise_with_full: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        $rose(noise) |-> rx_full) else $error("noise without full flag");
    chk_false_start_drop: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        false_start |=> rx_state == RX_IDLE) else $error("false start not dropped");
    chk_mute_no_flags: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        muted && !addr_wake && !clear_seq |=> !$rose(rx_full)) else $error("flag set while muted");
    chk_idle_wake: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        idle_wake && !WR_I |=> !ctrl2.mute_request && !$rose(idle_flag)) else $error("idle wake wrong");
    chk_addr_wake: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        addr_wake && !WR_I |=> !ctrl2.mute_request && rx_full) else $error("address wake wrong");
    chk_overrun_irq: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        overrun && ctrl2.rx_irq_en && !GLOB_MASK_I && !muted |-> IRQ_O) else $error("overrun irq missing");
    cov_overrun:     cover property (@(posedge CLOCK_I) do_overrun);
    cov_addr_wake:   cover property (@(posedge CLOCK_I) addr_wake);
    cov_false_start: cover property (@(posedge CLOCK_I) false_start);
endmodule

// File: dv/serial_peer.sv
// Far-end serial device that sends frames into the receiver
`timescale 1ns/1ps
module serial_peer (
    input  wire logic clock_i,
    input  wire logic line_i,
    output logic      line_o
);
    initial line_o = 1'b1;
    // Start, data LSB first, stop; the line idles high around frames
    // A bit time of idle first, so the receiver sees three ones before the edge
    task automatic send(input logic [9:0] fr, input int n, input int spb, input int glitch);
        repeat (spb) @(posedge clock_i);
        for (int i = 0; i < n; i++) begin
            for (int s = 0; s < spb; s++) begin
                // One flipped middle sample: the majority survives, the noise shows
                line_o <= (i == glitch && s == 8) ? ~fr[i] : fr[i];
                @(posedge clock_i);
            end
        end
        line_o <= 1'b1;
        repeat (3 * spb) @(posedge clock_i);
    endtask
    // Takes one frame from the block's transmitter, sampled in the middle of each bit
    task automatic take(input int spb, output logic [9:0] fr);
        @(negedge line_i);
        repeat (spb / 2) @(posedge clock_i);
        for (int i = 0; i < 10; i++) begin
            fr[i] = line_i;
            repeat (spb) @(posedge clock_i);
        end
    endtask
endmodule

// File: dv/uart_rx_error_baud_parity_bench.sv
// Bench for receive error flags, baud dividers, parity and mute wake-up
`timescale 1ns/1ps
module uart_rx_error_baud_parity_bench;
    import sci_rx_pkg::*;
    logic       clock, rst, wr, rd, glob_mask, tx_line, irq;
    logic [2:0] addr;
    logic [7:0] wdata, rdata;
    wire        rx_line;
    int         errors, checks_done;
    logic [9:0] got;
    logic [7:0] bsel [3] = '{8'h01, 8'h00, 8'h40};
    logic [7:0] fine [3] = '{8'h00, 8'h03, 8'h00};
    int         spb  [3] = '{32, 48, 48};

    sci_rx_core dut (.CLOCK_I(clock), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .GLOB_MASK_I(glob_mask), .RX_LINE_I(rx_line),
        .TX_LINE_O(tx_line), .IRQ_O(irq));
    serial_peer peer (.clock_i(clock), .line_i(tx_line), .line_o(rx_line));

    function automatic logic [9:0] fr(input logic [7:0] d, input logic stop);
        return {stop, d, 1'b0};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd_reg(input logic [2:0] a, input logic [7:0] mask, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk(rdata & mask, exp);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Longest path is well under 20000 cycles
    initial begin
        repeat (40000) @(posedge clock);
        errors++;
        complete_run();
    end
    initial begin
        {rst, wr, rd, glob_mask, addr, wdata} = {1'b1, 3'h0, 3'h0, 8'h00};
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rd_reg(ADDR_STATUS, 8'hff, STATUS_RESET);
        rd_reg(3'h7, 8'hff, 8'h00);
        wr_reg(ADDR_CTRL2, 8'h24);
        $display("reset test done");
        peer.send(fr(8'h11, 1'b1), 10, 16, -1);
        peer.send(fr(8'h22, 1'b1), 10, 16, -1);
        rd_reg(ADDR_STATUS, 8'h3f, 8'h28);
        chk({7'h0, irq}, 8'h01);
        glob_mask <= 1'b1;
        rd_reg(ADDR_DATA, 8'hff, 8'h11);
        chk({7'h0, irq}, 8'h00);
        glob_mask <= 1'b0;
        rd_reg(ADDR_STATUS, 8'h3f, 8'h00);
        $display("overrun test done");
        peer.send(fr(8'ha5, 1'b1), 10, 16, 4);
        rd_reg(ADDR_STATUS, 8'h3f, 8'h24);
        rd_reg(ADDR_DATA, 8'hff, 8'ha5);
        peer.send(fr(8'h3c, 1'b0), 10, 16, -1);
        rd_reg(ADDR_STATUS, 8'h3f, 8'h22);
        rd_reg(ADDR_DATA, 8'hff, 8'h3c);
        // A low pulse too short for a start bit leaves only hidden noise
        peer.send(10'h000, 1, 8, -1);
        rd_reg(ADDR_STATUS, 8'h3f, 8'h00);
        peer.send(fr(8'h66, 1'b1), 10, 16, -1);
        rd_reg(ADDR_STATUS, 8'h3f, 8'h24);
        rd_reg(ADDR_DATA, 8'hff, 8'h66);
        $display("noise and framing tests done");
        wr_reg(ADDR_CTRL1, 8'h05);
        peer.send(fr(8'h83, 1'b1), 10, 16, -1);
        rd_reg(ADDR_STATUS, 8'h3f, 8'h21);
        rd_reg(ADDR_DATA, 8'h7f, 8'h03);
        wr_reg(ADDR_CTRL1, 8'h06);
        peer.send(fr(8'h83, 1'b1), 10, 16, -1);
        rd_reg(ADDR_STATUS, 8'h3f, 8'h20);
        rd_reg(ADDR_DATA, 8'h7f, 8'h03);
        $display("parity test done");
        wr_reg(ADDR_CTRL1, 8'h08);
        // Mute is armed once; control two is left alone until the wake
        wr_reg(ADDR_CTRL2, 8'h26);
        peer.send(fr(8'h05, 1'b1), 10, 16, -1);
        rd_reg(ADDR_STATUS, 8'h3f, 8'h00);
        chk({7'h0, irq}, 8'h00);
        peer.send(fr(8'h85, 1'b1), 10, 16, -1);
        rd_reg(ADDR_CTRL2, 8'h02, 8'h00);
        rd_reg(ADDR_STATUS, 8'h3f, 8'h20);
        rd_reg(ADDR_DATA, 8'hff, 8'h85);
        $display("mute test done");
        // Even parity over seven bits of 0x83 is zero, so the sent MSB is zero
        wr_reg(ADDR_CTRL1, 8'h04);
        wr_reg(ADDR_CTRL2, 8'h08);
        wr_reg(ADDR_DATA, 8'h83);
        peer.take(16, got);
        chk(got[8:1], 8'h03);
        chk({6'h0, got[9], got[0]}, 8'h02);
        wr_reg(ADDR_CTRL1, 8'h00);
        $display("transmit test done");
        // Dividers change only with transmitter and receiver off
        for (int i = 0; i < 3; i++) begin
            wr_reg(ADDR_CTRL2, 8'h00);
            wr_reg(ADDR_BAUD, bsel[i]);
            wr_reg(ADDR_RX_FINE, fine[i]);
            wr_reg(ADDR_CTRL2, 8'h04);
            peer.send(fr(8'h96 ^ 8'(i), 1'b1), 10, spb[i], -1);
            rd_reg(ADDR_STATUS, 8'h3f, 8'h20);
            rd_reg(ADDR_DATA, 8'hff, 8'h96 ^ 8'(i));
        end
        $display("baud test done");
        complete_run();
    end
endmodule
